/* File: hw/flash_bus_host.sv */
// Host controller that drives the parallel flash bus pins for single operations.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Read: chip select and output enable low, write enable high; device drives data.
// - Write: chip select and write enable low, output enable high; device latches.
// - Each read, write or protect request makes one bus cycle; command sequences are left to the user.
// - After standby the host waits the chip-select access time before sampling.
// - Protect: reset at high voltage, select low, output enable high, write low, A6 low.
// - Unprotect uses the same levels with address bit 6 high.
module flash_bus_host #(
  parameter int ACCESS_CYCLES = flash_host_pkg::ACCESS_CYC,
  parameter int WRITE_CYCLES  = flash_host_pkg::WRITE_PULSE_CYC,
  parameter int RESET_CYCLES  = flash_host_pkg::RESET_PULSE_CYC,
  parameter int RECOVER_CYCLES = flash_host_pkg::RESET_HOLD_CYC
) (
  input  wire logic                              mclk,
  input  wire logic                              rst_b,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire flash_host_pkg::op_t               req_op,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
  input  wire logic                              req_byte_lo,
  input  wire logic [flash_host_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                              byte_mode,
  output logic                                   rsp_valid,
  output logic [flash_host_pkg::DATA_W-1:0]      rsp_rdata,
  output logic [flash_host_pkg::ADDR_W-1:0]      addr_out,
  output logic                                   chip_sel_b,
  output logic                                   out_en_b,
  output logic                                   wr_en_b,
  output logic                                   reset_b,
  output logic                                   high_voltage_level,
  output logic                                   width_word,
  input  wire logic [14:0]                       data_in,
  output logic [14:0]                            data_out,
  output logic                                   data_oe_b,
  input  wire logic                              top_data_or_byte_addr_in,
  output logic                                   top_data_or_byte_addr_out,
  output logic                                   top_data_or_byte_addr_oe_b,
  input  wire logic                              ready_busy_out
);

  localparam int CNT_W = 16;

  // Every count must fit the down-counter and be at least one cycle long
  if (ACCESS_CYCLES < 1 || WRITE_CYCLES < 1 || RESET_CYCLES < 1 || RECOVER_CYCLES < 1
      || ACCESS_CYCLES >= (1 << CNT_W) || WRITE_CYCLES >= (1 << CNT_W)
      || RESET_CYCLES >= (1 << CNT_W) || RECOVER_CYCLES >= (1 << CNT_W))
  begin : g_bad_counts
    $error("flash_bus_host: cycle counts out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    flash_host_pkg::state_t             st;
    flash_host_pkg::op_t                op;
    logic [CNT_W-1:0]                   cnt;
    logic [flash_host_pkg::ADDR_W-1:0]  addr;
    logic                               lo;
    logic                               bmode;
    logic [flash_host_pkg::DATA_W-1:0]  wdata;
    logic [flash_host_pkg::DATA_W-1:0]  rdata;
    logic                               rsp;
    logic                               cs_b;
    logic                               oe_b;
    logic                               we_b;
    logic                               rst_pin_b;
    logic                               hv;
    logic                               drive;
  } host_t;

  host_t s_reg;
  host_t s_next;

  function automatic logic is_write_like(input flash_host_pkg::op_t op);
    is_write_like = (op == flash_host_pkg::OP_WRITE) || (op == flash_host_pkg::OP_PROTECT)
                 || (op == flash_host_pkg::OP_UNPROTECT);
  endfunction : is_write_like

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction : cyc

  always_comb
  begin
    s_next     = s_reg;
    s_next.rsp = 1'b0;
    unique case (s_reg.st)
      flash_host_pkg::ST_IDLE:
      begin
        // Chip deselected and reset high between cycles puts the device in standby
        s_next.cs_b  = 1'b1;
        s_next.oe_b  = 1'b1;
        s_next.we_b  = 1'b1;
        s_next.drive = 1'b0;
        s_next.hv    = 1'b0;
        if (req_valid)
        begin
          s_next.op    = req_op;
          s_next.addr  = req_addr;
          s_next.lo    = req_byte_lo;
          s_next.bmode = byte_mode;
          s_next.wdata = req_wdata;
          s_next.cnt   = '0;
          if (req_op == flash_host_pkg::OP_RESET)
          begin
            s_next.rst_pin_b = 1'b0;
            s_next.cnt       = cyc(RESET_CYCLES);
            s_next.st        = flash_host_pkg::ST_RSTLOW;
          end
          else
          begin
            if (req_op == flash_host_pkg::OP_PROTECT || req_op == flash_host_pkg::OP_UNPROTECT)
            begin
              // Sector address with fixed low bits; bit 6 picks protect or unprotect
              s_next.addr[flash_host_pkg::PROT_A6] =
                (req_op == flash_host_pkg::OP_UNPROTECT);
              s_next.addr[flash_host_pkg::PROT_A1] = 1'b1;
              s_next.addr[flash_host_pkg::PROT_A0] = 1'b0;
              s_next.hv = 1'b1;
            end
            s_next.st = flash_host_pkg::ST_SETUP;
          end
        end
      end
      flash_host_pkg::ST_SETUP:
      begin
        // Address settles one cycle before the strobe
        s_next.cs_b = 1'b0;
        if (is_write_like(s_reg.op))
        begin
          s_next.oe_b  = 1'b1;
          s_next.we_b  = 1'b0;
          s_next.drive = 1'b1;
          s_next.cnt   = cyc(WRITE_CYCLES);
        end
        else
        begin
          s_next.we_b = 1'b1;
          s_next.oe_b = 1'b0;
          // Full chip-select access time, since every read leaves standby
          s_next.cnt  = cyc(ACCESS_CYCLES);
        end
        s_next.st = flash_host_pkg::ST_STROBE;
      end
      flash_host_pkg::ST_STROBE:
      begin
        if (s_reg.cnt != '0)
          s_next.cnt = s_reg.cnt - 1'b1;
        else
        begin
          if (!is_write_like(s_reg.op))
          begin
            // Byte-mode reads are byte wide in the low lane; word reads take all 16 pins
            s_next.rdata = s_reg.bmode ? {8'h00, data_in[7:0]}
                         : {top_data_or_byte_addr_in, data_in};
            s_next.rsp   = 1'b1;
          end
          else
            s_next.rsp = 1'b1;
          s_next.we_b = 1'b1;
          s_next.oe_b = 1'b1;
          s_next.st   = flash_host_pkg::ST_HOLD;
        end
      end
      flash_host_pkg::ST_HOLD:
      begin
        // Data and address held one cycle past the rising strobe; device may keep
        // running a program or erase after deselect, so busy is left to the user
        s_next.cs_b  = 1'b1;
        s_next.drive = 1'b0;
        s_next.hv    = 1'b0;
        s_next.st    = flash_host_pkg::ST_IDLE;
      end
      flash_host_pkg::ST_RSTLOW:
      begin
        if (s_reg.cnt != '0)
          s_next.cnt = s_reg.cnt - 1'b1;
        else
        begin
          s_next.rst_pin_b = 1'b1;
          s_next.cnt       = cyc(RECOVER_CYCLES);
          s_next.st        = flash_host_pkg::ST_RSTREC;
        end
      end
      flash_host_pkg::ST_RSTREC:
      begin
        // Device is back in read-array state after this wait
        if (s_reg.cnt != '0)
          s_next.cnt = s_reg.cnt - 1'b1;
        else
        begin
          s_next.rsp = 1'b1;
          s_next.st  = flash_host_pkg::ST_IDLE;
        end
      end
      default:
        s_next.st = flash_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      s_reg           <= '0;
      s_reg.st        <= flash_host_pkg::ST_IDLE;
      s_reg.op        <= flash_host_pkg::OP_READ;
      s_reg.cs_b      <= 1'b1;
      s_reg.oe_b      <= 1'b1;
      s_reg.we_b      <= 1'b1;
      s_reg.rst_pin_b <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign req_ready          = (s_reg.st == flash_host_pkg::ST_IDLE);
  assign rsp_valid          = s_reg.rsp;
  assign rsp_rdata          = s_reg.rdata;
  assign addr_out           = s_reg.addr;
  assign chip_sel_b         = s_reg.cs_b;
  assign out_en_b           = s_reg.oe_b;
  assign wr_en_b            = s_reg.we_b;
  assign reset_b            = s_reg.rst_pin_b;
  assign high_voltage_level = s_reg.hv;
  assign width_word         = ~s_reg.bmode;
  assign data_out           = s_reg.bmode ? {7'h00, s_reg.wdata[7:0]} : s_reg.wdata[14:0];
  // Byte-mode writes drive pins 8 to 14 low; the device floats those pins then
  assign data_oe_b          = ~s_reg.drive;
  // In byte mode pin 15 is always an address input of the device
  assign top_data_or_byte_addr_out  = s_reg.bmode ? s_reg.lo : s_reg.wdata[15];
  assign top_data_or_byte_addr_oe_b = ~(s_reg.drive | s_reg.bmode);

endmodule : flash_bus_host

`default_nettype wire

/* File: hw/flash_host_pkg.sv */
// Package with the timing counts, pin layouts and command codes of the flash bus host.
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int ACCESS_NS       = 120;
  localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_NS  = 50;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_NS  = 500;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_NS   = 50;
  localparam int RESET_HOLD_CYC  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Pin layout
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 16;
  localparam int PROT_A6    = 6;
  localparam int PROT_A1    = 1;
  localparam int PROT_A0    = 0;

  // ----------------------------------------------------------------
  // Operations requested by the user side
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_WRITE     = 3'h1,
    OP_RESET     = 3'h2,
    OP_PROTECT   = 3'h3,
    OP_UNPROTECT = 3'h4
  } op_t;

  // Gray order along idle -> setup -> strobe -> hold
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_RSTLOW = 3'b110,
    ST_RSTREC = 3'b111
  } state_t;

endpackage : flash_host_pkg

/* File: tb/flash_dev_model.sv */
// Behavioural model of the parallel flash device on the host's pins
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] ID_CODE = 8'h3c  // Arbitrary value
) (
  input  wire logic [19:0] addr_out,
  input  wire logic        chip_sel_b,
  input  wire logic        out_en_b,
  input  wire logic        wr_en_b,
  input  wire logic        reset_b,
  input  wire logic        high_voltage_level,
  input  wire logic        width_word,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_drv,
  output logic             ready_busy_out,
  output logic [19:0]      cmd_addr,
  output logic             cmd_hv
);
  localparam logic [7:0] BUSY_CMD = 8'h6d;  // Arbitrary code that starts a long operation
  localparam logic [7:0] STATUS   = 8'h4c;  // Arbitrary status byte shown while busy
  logic        auto_mode = 1'b0;
  logic        busy = 1'b0;
  logic [15:0] word;
  assign ready_busy_out = ~busy;
  // Command latches keep the address and high-voltage level along with the mode they select
  always @(posedge wr_en_b or negedge reset_b)
    if (!reset_b)
    begin
      auto_mode <= 1'b0;
      busy      <= 1'b0;
    end
    else if (!chip_sel_b && out_en_b)
    begin
      cmd_addr <= addr_out;
      cmd_hv <= high_voltage_level;
      if (dq_in[7:0] === 8'h90)
        auto_mode <= 1'b1;
      else if (dq_in[7:0] === 8'hf0)
        auto_mode <= 1'b0;
      else if (dq_in[7:0] === BUSY_CMD)
      begin
        // Runs on through deselect; only a reset cuts it short
        busy <= 1'b1;
        busy <= #2000 1'b0;
      end
    end
  // Released pins show the inverse so a stale sample never matches
  always @*
  begin
    word = auto_mode ? {8'h00, ID_CODE} : (addr_out[15:0] ^ 16'ha5c3);
    if (busy)
      word = {8'h00, STATUS};
    if (!width_word)
      word = {8'h00, dq_in[15] ? word[15:8] : word[7:0]};
    if (!chip_sel_b && !out_en_b && wr_en_b && reset_b)
      dq_drv = width_word ? word : {~word[15:8], word[7:0]};
    else
      dq_drv = ~word;
  end
endmodule : flash_dev_model
`default_nettype wire

/* File: tb/flash_bus_host_checker.sv */
// Checker of the host's pin sequencing, bound to the host module
`timescale 1ns/10ps
`default_nettype none
module flash_bus_host_checker #(
  parameter int ACCESS_CYCLES = 2,
  parameter int RESET_CYCLES  = 5
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        rsp_valid,
  input wire logic [19:0] addr_out,
  input wire logic        chip_sel_b,
  input wire logic        out_en_b,
  input wire logic        wr_en_b,
  input wire logic        reset_b,
  input wire logic        high_voltage_level,
  input wire logic        width_word,
  input wire logic        data_oe_b,
  input wire logic        top_data_or_byte_addr_oe_b
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  int unsigned lo_cnt;
  // Length of the current output-enable or reset pulse
  always_ff @(posedge mclk)
    if (!rst_b || (out_en_b && reset_b))
      lo_cnt <= 0;
    else
      lo_cnt <= lo_cnt + 1;
  property p_read_lvl; !out_en_b |-> !chip_sel_b && wr_en_b && data_oe_b; endproperty
  a_read_lvl: assert property (p_read_lvl) else $error("read levels wrong");
  property p_write_lvl; !wr_en_b |-> !chip_sel_b && out_en_b; endproperty
  a_write_lvl: assert property (p_write_lvl) else $error("write levels wrong");
  property p_idle; chip_sel_b |-> out_en_b && wr_en_b && data_oe_b; endproperty
  a_idle: assert property (p_idle) else $error("strobe while deselected");
  property p_access; $rose(out_en_b) |-> lo_cnt == ACCESS_CYCLES && rsp_valid; endproperty
  a_access: assert property (p_access) else $error("access wait wrong");
  property p_rst_pulse; $rose(reset_b) |-> lo_cnt == RESET_CYCLES; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length");
  property p_wr_done; $rose(wr_en_b) |-> rsp_valid && !chip_sel_b ##1 chip_sel_b; endproperty
  a_wr_done: assert property (p_wr_done) else $error("write end wrong");
  property p_hv; high_voltage_level |-> out_en_b && addr_out[1] && !addr_out[0]; endproperty
  a_hv: assert property (p_hv) else $error("protect levels wrong");
  property p_byte; !width_word && !chip_sel_b |-> !top_data_or_byte_addr_oe_b; endproperty
  a_byte: assert property (p_byte) else $error("byte address pin idle");
endmodule : flash_bus_host_checker
bind flash_bus_host flash_bus_host_checker #(
  .ACCESS_CYCLES(ACCESS_CYCLES),
  .RESET_CYCLES (RESET_CYCLES)
) u_chk (.mclk, .rst_b, .rsp_valid, .addr_out, .chip_sel_b, .out_en_b, .wr_en_b, .reset_b,
  .high_voltage_level, .width_word, .data_oe_b, .top_data_or_byte_addr_oe_b);
`default_nettype wire

/* File: tb/flash_bus_host_tb.sv */
// Testbench of the flash bus host facing a behavioural flash device
`timescale 1ns/10ps
`default_nettype none
module flash_bus_host_tb;
  logic                mclk = 1'b0;
  logic                rst_b = 1'b0;
  logic                req_valid = 1'b0;
  logic                byte_mode = 1'b0;
  logic                req_byte_lo = 1'b0;
  flash_host_pkg::op_t req_op = flash_host_pkg::OP_READ;
  logic [19:0]         req_addr = 20'h00000;
  logic [15:0]         req_wdata = 16'h0000;
  logic                req_ready, rsp_valid, chip_sel_b, out_en_b, wr_en_b, reset_b, hv;
  logic                width_word, data_oe_b, top_out, top_oe_b, ready_busy_out, cmd_hv;
  logic [15:0]         rsp_rdata, dev_dq, got;
  logic [14:0]         data_out;
  logic [19:0]         addr_out, cmd_addr;
  int                  errors = 0;
  int                  cmp_count = 0;
  wire logic [15:0]    dq = {top_oe_b ? dev_dq[15] : top_out, data_oe_b ? dev_dq[14:0] : data_out};
  flash_bus_host u_dut (.mclk, .rst_b, .req_valid, .req_ready, .req_op, .req_addr, .req_byte_lo,
    .req_wdata, .byte_mode, .rsp_valid, .rsp_rdata, .addr_out, .chip_sel_b, .out_en_b,
    .wr_en_b, .reset_b, .high_voltage_level(hv), .width_word, .data_in(dq[14:0]), .data_out,
    .data_oe_b, .top_data_or_byte_addr_in(dq[15]), .top_data_or_byte_addr_out(top_out),
    .top_data_or_byte_addr_oe_b(top_oe_b), .ready_busy_out);
  flash_dev_model u_dev (.addr_out, .chip_sel_b, .out_en_b, .wr_en_b, .reset_b,
    .high_voltage_level(hv), .width_word, .dq_in(dq), .dq_drv(dev_dq), .ready_busy_out,
    .cmd_addr, .cmd_hv);
  initial forever #50 mclk = ~mclk;
  function automatic logic [15:0] pat(input logic [19:0] a);
    return a[15:0] ^ 16'ha5c3;
  endfunction : pat
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Holds the request until taken, then waits for the answer pulse
  task automatic do_op(input flash_host_pkg::op_t op, input logic [19:0] a, input logic [15:0] wd);
    int n;
    req_op <= op;
    req_addr <= a;
    req_wdata <= wd;
    req_valid <= 1'b1;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(posedge mclk);
    if (n == 20) chk("answer", 16'h0001, 16'h0000);
    got = rsp_rdata;
  endtask : do_op
  task automatic t_array;
    do_op(flash_host_pkg::OP_READ, 20'h12345, 16'h0000);
    chk("word read", pat(20'h12345), got);
    do_op(flash_host_pkg::OP_READ, 20'hfffff, 16'h0000);
    chk("last word", pat(20'hfffff), got);
  endtask : t_array
  task automatic t_bytes;
    byte_mode <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      req_byte_lo <= i[0];
      do_op(flash_host_pkg::OP_READ, 20'h0abcd, 16'h0000);
      chk("byte read", i[0] ? pat(20'h0abcd) >> 8 : pat(20'h0abcd) & 16'h00ff, got);
    end
    byte_mode <= 1'b0;
  endtask : t_bytes
  task automatic t_auto(input logic do_reset);
    do_op(flash_host_pkg::OP_WRITE, 20'h00555, 16'h0090);
    do_op(flash_host_pkg::OP_READ, 20'h00001, 16'h0000);
    chk("id read", 16'h003c, got);
    if (do_reset)
      do_op(flash_host_pkg::OP_RESET, 20'h00000, 16'h0000);
    else
      do_op(flash_host_pkg::OP_WRITE, 20'h00000, 16'h00f0);
    do_op(flash_host_pkg::OP_READ, 20'h00001, 16'h0000);
    chk("array again", pat(20'h00001), got);
  endtask : t_auto
  task automatic t_prot;
    for (int u = 0; u < 2; u++)
    begin
      do_op(u[0] ? flash_host_pkg::OP_UNPROTECT : flash_host_pkg::OP_PROTECT, 20'hf8041, 16'h0000);
      chk("protect pins", {12'h000, 1'b1, u[0], 2'b10}, {12'h000, cmd_hv, cmd_addr[6], cmd_addr[1:0]});
      chk("sector addr", 16'h00f8, {8'h00, cmd_addr[19:12]});
    end
  endtask : t_prot
  // Long operation: status reads while busy, completion through deselect
  task automatic t_busy;
    int n;
    do_op(flash_host_pkg::OP_WRITE, 20'h00000, 16'h006d);
    do_op(flash_host_pkg::OP_READ, 20'h00002, 16'h0000);
    chk("status read", 16'h004c, got);
    chk("busy after deselect", 16'h0000, {15'h0000, ready_busy_out});
    for (n = 0; n < 40 && ready_busy_out !== 1'b1; n++) @(posedge mclk);
    chk("operation completes", 16'h0001, {15'h0000, ready_busy_out});
    do_op(flash_host_pkg::OP_READ, 20'h00002, 16'h0000);
    chk("array after busy", pat(20'h00002), got);
  endtask : t_busy
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_array();
    t_bytes();
    t_auto(1'b0);
    t_prot();
    t_auto(1'b1);
    t_busy();
    close_out();
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule : flash_bus_host_tb
`default_nettype wire
